//--- core/csci_pkg.sv
// Behaviour
// - Ignore input active: pending error is disregarded
// - Ignore inactive: noncontrol instruction raises exception
// - Native error reporting bit overrides ignore input
// - Ignore value valid when target ready asserted
// - Soft init resets integer state only
// - After soft init fetch configured reset vector
// - Snoops still answered during soft init
// - Soft init at reset release starts self-test
// - Soft init asynchronous, wired to every agent
// - Controller disabled: inputs become maskable, nonmaskable
// - Controller enabled after reset by default
// - Local interrupt inputs accepted asynchronously
// - Lock held from first start to last end
// - Priority agent waits for lock deasserted
// - Two data lines carry serial messages, bus clock
package csci_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchroniser vector layout
  localparam int        SYNC_W    = 8;
  localparam int        IDX_IGN   = 0;
  localparam int        IDX_INIT  = 1;
  localparam int        IDX_LOCAL_IRQ_IN_0 = 2;
  localparam int        IDX_LOCAL_IRQ_IN_1 = 3;
  localparam int        IDX_RST   = 4;
  localparam int        IDX_PCLK  = 5;
  localparam int        IDX_PD    = 6;
  localparam logic [7:0] SYNC_RST = 8'hc3;  // Inactive levels, bus reset held

  ////////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int         VEC_W         = 32;
  localparam logic [31:0] VEC_RST      = 32'h0000_0000;
  localparam logic       CTRL_EN_RST   = 1'b1;
  localparam int         PCLK_HALF     = 4;  // Host clk cycles per irq bus clock half
  localparam logic [2:0] PCLK_HALF_M1  = 3'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // State machines
  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_HELD = 2'b10
  } csci_lock_type;

  typedef enum logic [2:0] {
    PR_IDLE = 3'b001,
    PR_WAIT = 3'b010,
    PR_OWN  = 3'b100
  } csci_prio_type;

endpackage

//--- core/csci_if.sv
interface csci_if (
  input wire logic clk,
  input wire logic arst_n
);
  logic       numeric_error_ignore_n;
  logic       target_ready_n;
  logic       soft_init_n;
  logic       bus_reset_n;
  logic [1:0] local_irq_in;
  logic       snoop_req;
  logic       snoop_ack;
  logic       lock_o;
  logic       lock_oe_n;
  logic       bus_lock_n;
  logic       priority_bus_request_n;
  logic       irq_bus_clock;
  logic [1:0] dev_pd_o;
  logic [1:0] dev_pd_oe_n;
  logic [1:0] host_pd_o;
  logic [1:0] host_pd_oe_n;
  logic [1:0] irq_bus_data;

  // Open-drain resolution of the shared wires
  assign bus_lock_n   = lock_oe_n | lock_o;
  assign irq_bus_data = (dev_pd_oe_n | dev_pd_o) & (host_pd_oe_n | host_pd_o);

  modport dev (
    input  numeric_error_ignore_n, target_ready_n, soft_init_n, bus_reset_n,
    input  local_irq_in, snoop_req, bus_lock_n, priority_bus_request_n,
    input  irq_bus_clock, irq_bus_data,
    output snoop_ack, lock_o, lock_oe_n, dev_pd_o, dev_pd_oe_n
  );

  modport host (
    output numeric_error_ignore_n, target_ready_n, soft_init_n, bus_reset_n,
    output local_irq_in, snoop_req, priority_bus_request_n, irq_bus_clock,
    output host_pd_o, host_pd_oe_n,
    input  snoop_ack, bus_lock_n, irq_bus_data
  );
endinterface

//--- core/csci_device.sv
module csci_device (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  csci_if.dev                        sb,
  input  wire logic                  ne_bit,
  input  wire logic                  fp_error_set,
  input  wire logic                  fp_error_clear,
  input  wire logic                  fp_issue,
  output logic                       fp_exception,
  output logic                       fp_proceed,
  input  wire logic [csci_pkg::VEC_W-1:0] reset_vector_strap,
  output logic                       int_regs_reset,
  output logic                       fetch_restart,
  output logic [csci_pkg::VEC_W-1:0] fetch_addr,
  output logic                       bist_start,
  input  wire logic                  ctrl_cfg_wr,
  input  wire logic                  ctrl_cfg_enable,
  output logic                       ctrl_enabled,
  output logic [1:0]                 local_irq_event,
  output logic                       maskable_irq_req,
  output logic                       nmi_pulse,
  input  wire logic                  txn_start,
  input  wire logic                  txn_locked,
  input  wire logic                  txn_end,
  input  wire logic                  txn_last,
  output logic                       lock_active,
  input  wire logic                  irq_tx_en,
  input  wire logic [1:0]            irq_tx_bits,
  output logic [1:0]                 irq_rx_bits,
  output logic                       irq_rx_valid
);
  import csci_pkg::*;

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [SYNC_W-1:0] prev_r;
  logic              fp_pending_r;
  logic              ign_eff;
  logic [VEC_W-1:0]  vector_r;
  logic              ctrl_en_r;
  csci_lock_type     lock_r;
  csci_lock_type     lock_nxt;
  logic [SYNC_W-1:0] raw_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the eight sideband bits in raw_in; snoop_req is used unsynchronised
  assign raw_in = {sb.irq_bus_data, sb.irq_bus_clock, sb.bus_reset_n,
                   sb.local_irq_in[1], sb.local_irq_in[0], sb.soft_init_n,
                   sb.numeric_error_ignore_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      // First stage read only by the second
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r[gi] <= SYNC_RST[gi];
          sync_r[gi] <= SYNC_RST[gi];
          prev_r[gi] <= SYNC_RST[gi];
        end else begin
          meta_r[gi] <= raw_in[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Numeric error handling
  assign ign_eff = !sync_r[IDX_IGN] && !ne_bit;

  // Pending error flag, a new error beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fp_pending_r <= 1'b0;
    end else if (fp_error_set) begin
      fp_pending_r <= 1'b1;
    end else if (fp_error_clear) begin
      fp_pending_r <= 1'b0;
    end
  end

  // Issue outcome for a noncontrol instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fp_exception <= 1'b0;
      fp_proceed   <= 1'b0;
    end else begin
      fp_exception <= fp_issue && fp_pending_r && !ign_eff;
      fp_proceed   <= fp_issue && (!fp_pending_r || ign_eff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset vector capture and self-test request at bus reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_r   <= VEC_RST;
      bist_start <= 1'b0;
    end else begin
      bist_start <= 1'b0;
      if (sync_r[IDX_RST] && !prev_r[IDX_RST]) begin
        vector_r   <= reset_vector_strap;
        bist_start <= !sync_r[IDX_INIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Soft init: integer reset and restart at the configured vector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_regs_reset <= 1'b0;
      fetch_restart  <= 1'b0;
      fetch_addr     <= VEC_RST;
    end else begin
      int_regs_reset <= 1'b0;
      fetch_restart  <= 1'b0;
      if (!sync_r[IDX_INIT] && prev_r[IDX_INIT] && sync_r[IDX_RST]) begin
        int_regs_reset <= 1'b1;
        fetch_restart  <= 1'b1;
        fetch_addr     <= vector_r;
      end
    end
  end

  // Snoops answered whatever the soft init level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sb.snoop_ack <= 1'b0;
    end else begin
      sb.snoop_ack <= sb.snoop_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Local interrupt controller enable and pin routing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_en_r <= CTRL_EN_RST;
    end else if (!sync_r[IDX_RST]) begin
      ctrl_en_r <= CTRL_EN_RST;
    end else if (ctrl_cfg_wr) begin
      ctrl_en_r <= ctrl_cfg_enable;
    end
  end

  assign ctrl_enabled = ctrl_en_r;

  // Route synchronised pins to controller or legacy interrupts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      local_irq_event  <= 2'h0;
      maskable_irq_req <= 1'b0;
      nmi_pulse        <= 1'b0;
    end else begin
      local_irq_event  <= ctrl_en_r ? sync_r[IDX_LOCAL_IRQ_IN_1:IDX_LOCAL_IRQ_IN_0] : 2'h0;
      maskable_irq_req <= !ctrl_en_r && sync_r[IDX_LOCAL_IRQ_IN_0];
      nmi_pulse        <= !ctrl_en_r && sync_r[IDX_LOCAL_IRQ_IN_1] && !prev_r[IDX_LOCAL_IRQ_IN_1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lock across an atomic sequence
  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      LK_IDLE: begin
        if (txn_start && txn_locked) begin
          lock_nxt = LK_HELD;
        end
      end
      LK_HELD: begin
        if (txn_end && txn_last) begin
          lock_nxt = LK_IDLE;
        end
      end
      default: lock_nxt = LK_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_r <= LK_IDLE;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // Lock wire pulled low only while held
  assign sb.lock_o    = 1'b0;
  assign sb.lock_oe_n = (lock_r != LK_HELD);
  assign lock_active  = (lock_r == LK_HELD);

  ////////////////////////////////////////////////////////////////////////////////
  // Serial message lines timed by the irq bus clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_rx_bits  <= 2'h0;
      irq_rx_valid <= 1'b0;
    end else begin
      irq_rx_valid <= 1'b0;
      if (sync_r[IDX_PCLK] && !prev_r[IDX_PCLK]) begin
        irq_rx_bits  <= sync_r[IDX_PD+1:IDX_PD];
        irq_rx_valid <= 1'b1;
      end
    end
  end

  // Drive new bits on the falling edge of the irq bus clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sb.dev_pd_o    <= 2'h3;
      sb.dev_pd_oe_n <= 2'h3;
    end else if (!sync_r[IDX_PCLK] && prev_r[IDX_PCLK]) begin
      sb.dev_pd_o    <= irq_tx_bits;
      sb.dev_pd_oe_n <= irq_tx_en ? 2'h0 : 2'h3;
    end
  end

endmodule // csci_device

//--- core/csci_host.sv
module csci_host (
  input  wire logic       clk,
  input  wire logic       arst_n,
  csci_if.host            sb,
  input  wire logic       bus_reset_req,
  input  wire logic       soft_init_req,
  input  wire logic       io_wr_req,
  input  wire logic       io_wr_ignore,
  input  wire logic [1:0] lint_req,
  input  wire logic       snoop_issue,
  output logic            snoop_done,
  input  wire logic       prio_req,
  input  wire logic       prio_release,
  output logic            prio_granted,
  input  wire logic       irq_tx_en,
  input  wire logic [1:0] irq_tx_bits,
  output logic [1:0]      irq_rx_bits,
  output logic            irq_rx_valid
);
  import csci_pkg::*;

  csci_prio_type prio_r;
  csci_prio_type prio_nxt;
  logic [2:0]    div_r;
  logic          pclk_r;
  logic          tready_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Sideband levels, registered for a clean drive to every agent
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sb.bus_reset_n  <= 1'b0;
      sb.soft_init_n  <= 1'b1;
      sb.local_irq_in <= 2'h0;
      sb.snoop_req    <= 1'b0;
      snoop_done      <= 1'b0;
    end else begin
      sb.bus_reset_n  <= !bus_reset_req;
      sb.soft_init_n  <= !soft_init_req;
      sb.local_irq_in <= lint_req;
      sb.snoop_req    <= snoop_issue;
      snoop_done      <= sb.snoop_ack;
    end
  end

  // Ignore value set with the I/O write, target ready in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sb.numeric_error_ignore_n <= 1'b1;
      tready_r                  <= 1'b0;
    end else begin
      tready_r <= io_wr_req;
      if (io_wr_req) begin
        sb.numeric_error_ignore_n <= !io_wr_ignore;
      end
    end
  end

  assign sb.target_ready_n = !tready_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Priority request waits for the lock to drop
  always_comb begin
    prio_nxt = prio_r;
    case (prio_r)
      PR_IDLE: begin
        if (prio_req) begin
          prio_nxt = PR_WAIT;
        end
      end
      PR_WAIT: begin
        if (sb.bus_lock_n) begin
          prio_nxt = PR_OWN;
        end
      end
      PR_OWN: begin
        if (prio_release) begin
          prio_nxt = PR_IDLE;
        end
      end
      default: prio_nxt = PR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prio_r <= PR_IDLE;
    end else begin
      prio_r <= prio_nxt;
    end
  end

  assign sb.priority_bus_request_n = (prio_r == PR_IDLE);
  assign prio_granted              = (prio_r == PR_OWN);

  ////////////////////////////////////////////////////////////////////////////////
  // Irq bus clock divider and message lines
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r  <= 3'h0;
      pclk_r <= 1'b0;
    end else if (div_r == PCLK_HALF_M1) begin
      div_r  <= 3'h0;
      pclk_r <= !pclk_r;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  assign sb.irq_bus_clock = pclk_r;

  // Drive on falling edge, sample on rising edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sb.host_pd_o    <= 2'h3;
      sb.host_pd_oe_n <= 2'h3;
      irq_rx_bits     <= 2'h0;
      irq_rx_valid    <= 1'b0;
    end else begin
      irq_rx_valid <= 1'b0;
      if (div_r == PCLK_HALF_M1 && pclk_r) begin
        sb.host_pd_o    <= irq_tx_bits;
        sb.host_pd_oe_n <= irq_tx_en ? 2'h0 : 2'h3;
      end
      if (div_r == PCLK_HALF_M1 && !pclk_r) begin
        irq_rx_bits  <= sb.irq_bus_data;
        irq_rx_valid <= 1'b1;
      end
    end
  end

endmodule // csci_host

//--- bench/csci_checker.sv
module csci_checker (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       numeric_error_ignore_n,
  input wire logic       target_ready_n,
  input wire logic       soft_init_n,
  input wire logic       snoop_req,
  input wire logic       snoop_ack,
  input wire logic       lock_oe_n,
  input wire logic       bus_lock_n,
  input wire logic       irq_bus_clock,
  input wire logic [1:0] host_pd_o,
  input wire logic [1:0] host_pd_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Halves of the interrupt bus clock, four clk cycles each
  sequence s_high_half;
    irq_bus_clock [*3] ##1 !irq_bus_clock;
  endsequence

  sequence s_low_half;
    !irq_bus_clock [*3] ##1 irq_bus_clock;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Snoop answers keep coming, also while soft init is held
  chk_ack_follows_req: assert property (1'b1 |=> snoop_ack == $past(snoop_req))
    else $error("snoop ack does not follow the request");
  chk_snoop_in_init: assert property (!soft_init_n && snoop_req |=> snoop_ack)
    else $error("snoop not answered during soft init");

  // Ignore level only moves together with a one-cycle target ready
  chk_target_ready_n_single: assert property ($fell(target_ready_n) |=> target_ready_n)
    else $error("target ready held longer than one cycle");
  chk_ignore_with_target_ready_n: assert property ($changed(numeric_error_ignore_n) |-> !target_ready_n)
    else $error("ignore level changed without target ready");

  // Interrupt bus clock shape and host data hold
  chk_pclk_high_half: assert property ($rose(irq_bus_clock) |=> s_high_half)
    else $error("irq bus clock high half wrong");
  chk_pclk_low_half: assert property ($fell(irq_bus_clock) |=> s_low_half)
    else $error("irq bus clock low half wrong");
  chk_host_pd_hold: assert property (irq_bus_clock |-> $stable(host_pd_o) && $stable(host_pd_oe_n))
    else $error("host data moved while irq bus clock high");

  // An enabled lock driver pulls the shared lock line low
  chk_lock_drive_low: assert property (!lock_oe_n |-> !bus_lock_n)
    else $error("lock enabled but line not low");
endmodule // csci_checker

//--- bench/csci_tb_top.sv
module csci_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] STRAP = 32'h0010_2000;
  logic clk, arst_n, ne_bit, fp_error_set, fp_error_clear, fp_issue, fp_exception, fp_proceed;
  logic int_regs_reset, fetch_restart, bist_start, ctrl_cfg_wr, ctrl_cfg_enable, ctrl_enabled;
  logic maskable_irq_req, nmi_pulse, txn_start, txn_locked, txn_end, txn_last, lock_active;
  logic irq_tx_en, irq_rx_valid, bus_reset_req, soft_init_req, io_wr_req, io_wr_ignore;
  logic snoop_issue, snoop_done, prio_req, prio_release, prio_granted, h_tx_en, h_rx_valid;
  logic [1:0] local_irq_event, irq_tx_bits, irq_rx_bits, lint_req, h_tx_bits, h_rx_bits;
  logic [31:0] reset_vector_strap, fetch_addr;
  int mismatches, samples_checked;

  ////////////////////////////////////////////////////////////////////////////////
  // Both ends joined by the sideband interface
  csci_if sb (.clk(clk), .arst_n(arst_n));
  csci_device u_csci_device (.clk, .arst_n, .sb(sb.dev), .ne_bit, .fp_error_set,
    .fp_error_clear, .fp_issue, .fp_exception, .fp_proceed, .reset_vector_strap,
    .int_regs_reset, .fetch_restart, .fetch_addr, .bist_start, .ctrl_cfg_wr,
    .ctrl_cfg_enable, .ctrl_enabled, .local_irq_event, .maskable_irq_req, .nmi_pulse,
    .txn_start, .txn_locked, .txn_end, .txn_last, .lock_active, .irq_tx_en, .irq_tx_bits,
    .irq_rx_bits, .irq_rx_valid);
  csci_host u_csci_host (.clk, .arst_n, .sb(sb.host), .bus_reset_req, .soft_init_req,
    .io_wr_req, .io_wr_ignore, .lint_req, .snoop_issue, .snoop_done, .prio_req,
    .prio_release, .prio_granted, .irq_tx_en(h_tx_en), .irq_tx_bits(h_tx_bits),
    .irq_rx_bits(h_rx_bits), .irq_rx_valid(h_rx_valid));
  csci_checker u_csci_checker (.clk, .arst_n,
    .numeric_error_ignore_n(sb.numeric_error_ignore_n), .target_ready_n(sb.target_ready_n),
    .soft_init_n(sb.soft_init_n), .snoop_req(sb.snoop_req), .snoop_ack(sb.snoop_ack),
    .lock_oe_n(sb.lock_oe_n), .bus_lock_n(sb.bus_lock_n), .irq_bus_clock(sb.irq_bus_clock),
    .host_pd_o(sb.host_pd_o), .host_pd_oe_n(sb.host_pd_oe_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  // Host I/O write sets the ignore level with a target ready pulse
  task automatic io_write(input logic ign);
    @(posedge clk);
    io_wr_ignore <= ign;
    io_wr_req <= 1'b1;
    @(posedge clk);
    io_wr_req <= 1'b0;
    #1;
    chkb("target_ready_n", 1'b0, sb.target_ready_n);
    chkb("ignore_n", !ign, sb.numeric_error_ignore_n);
    repeat (4) @(posedge clk);
  endtask

  // One floating-point issue and its one-cycle answer
  task automatic fp_try(input logic ne, input logic exc);
    @(posedge clk);
    ne_bit <= ne;
    @(posedge clk);
    fp_issue <= 1'b1;
    @(posedge clk);
    fp_issue <= 1'b0;
    #1;
    chkb("fp_exception", exc, fp_exception);
    chkb("fp_proceed", !exc, fp_proceed);
  endtask

  task automatic fp_pend(input logic set);
    @(posedge clk);
    fp_error_set <= set;
    fp_error_clear <= !set;
    @(posedge clk);
    fp_error_set <= 1'b0;
    fp_error_clear <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset(input logic init);
    @(posedge clk);
    bus_reset_req <= 1'b1;
    soft_init_req <= init;
    repeat (8) @(posedge clk);
    #1;
    chkb("ctrl_enabled", 1'b1, ctrl_enabled);
    @(posedge clk);
    bus_reset_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chkb("bist_start", init, bist_start);
    @(posedge clk);
    soft_init_req <= 1'b0;
    repeat (6) @(posedge clk);
    $display("t_reset done");
  endtask

  task automatic t_fp;
    fp_pend(1'b1);
    io_write(1'b0);
    fp_try(1'b0, 1'b1);
    fp_try(1'b0, 1'b1);
    io_write(1'b1);
    fp_try(1'b0, 1'b0);
    fp_try(1'b1, 1'b1);
    fp_pend(1'b0);
    fp_try(1'b1, 1'b0);
    $display("t_fp done");
  endtask

  task automatic t_init;
    fp_pend(1'b1);
    @(posedge clk);
    soft_init_req <= 1'b1;
    snoop_issue <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chkb("int_regs_reset", 1'b1, int_regs_reset);
    chkb("fetch_restart", 1'b1, fetch_restart);
    chk("fetch_addr", STRAP, fetch_addr);
    chkb("snoop_done", 1'b1, snoop_done);
    @(posedge clk);
    snoop_issue <= 1'b0;
    soft_init_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chkb("snoop_done", 1'b0, snoop_done);
    fp_try(1'b1, 1'b1);
    fp_pend(1'b0);
    $display("t_init done");
  endtask

  task automatic t_lint;
    int n;
    n = 0;
    @(posedge clk);
    lint_req <= 2'b10;
    repeat (6) @(posedge clk);
    #1;
    chk("local_irq_event", 32'h2, {30'h0, local_irq_event});
    chkb("maskable_irq_req", 1'b0, maskable_irq_req);
    @(posedge clk);
    lint_req <= 2'b00;
    ctrl_cfg_enable <= 1'b0;
    ctrl_cfg_wr <= 1'b1;
    @(posedge clk);
    ctrl_cfg_wr <= 1'b0;
    #1;
    chkb("ctrl_enabled", 1'b0, ctrl_enabled);
    @(posedge clk);
    lint_req <= 2'b01;
    repeat (6) @(posedge clk);
    #1;
    chkb("maskable_irq_req", 1'b1, maskable_irq_req);
    @(posedge clk);
    lint_req <= 2'b10;
    repeat (8) begin
      @(posedge clk);
      #1;
      n += (nmi_pulse === 1'b1) ? 1 : 0;
    end
    chk("nmi_count", 32'h1, n);
    chkb("maskable_irq_req", 1'b0, maskable_irq_req);
    @(posedge clk);
    lint_req <= 2'b00;
    $display("t_lint done");
  endtask

  task automatic t_lock;
    @(posedge clk);
    txn_start <= 1'b1;
    txn_locked <= 1'b1;
    prio_req <= 1'b1;
    @(posedge clk);
    txn_start <= 1'b0;
    txn_locked <= 1'b0;
    prio_req <= 1'b0;
    #1;
    chkb("bus_lock_n", 1'b0, sb.bus_lock_n);
    @(posedge clk);
    txn_end <= 1'b1;
    @(posedge clk);
    txn_end <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chkb("lock_active", 1'b1, lock_active);
    chkb("prio_granted", 1'b0, prio_granted);
    chkb("prio_req_n", 1'b0, sb.priority_bus_request_n);
    @(posedge clk);
    txn_end <= 1'b1;
    txn_last <= 1'b1;
    @(posedge clk);
    txn_end <= 1'b0;
    txn_last <= 1'b0;
    #1;
    chkb("lock_active", 1'b0, lock_active);
    repeat (6) @(posedge clk);
    #1;
    chkb("prio_granted", 1'b1, prio_granted);
    @(posedge clk);
    prio_release <= 1'b1;
    @(posedge clk);
    prio_release <= 1'b0;
    $display("t_lock done");
  endtask

  task automatic t_irq(input logic dev, input logic [1:0] bits);
    int k;
    k = 0;
    @(posedge clk);
    irq_tx_en <= dev;
    h_tx_en <= !dev;
    irq_tx_bits <= bits;
    h_tx_bits <= bits;
    repeat (20) @(posedge clk);
    #1;
    while (k < 16 && (dev ? h_rx_valid : irq_rx_valid) !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
    end
    chkb("rx_valid", 1'b1, k < 16);
    chk("rx_bits", {30'h0, bits}, {30'h0, dev ? h_rx_bits : irq_rx_bits});
    chk("irq_bus_data", {30'h0, bits}, {30'h0, sb.irq_bus_data});
    @(posedge clk);
    irq_tx_en <= 1'b0;
    h_tx_en <= 1'b0;
    $display("t_irq done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    {arst_n, ne_bit, fp_error_set, fp_error_clear, fp_issue, ctrl_cfg_wr} = '0;
    {txn_start, txn_locked, txn_end, txn_last, irq_tx_en, soft_init_req} = '0;
    {io_wr_req, io_wr_ignore, snoop_issue, prio_req, prio_release, h_tx_en} = '0;
    {irq_tx_bits, lint_req, h_tx_bits} = '0;
    ctrl_cfg_enable = 1'b1;
    bus_reset_req = 1'b1;
    reset_vector_strap = STRAP;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_reset(1'b0);
    t_fp();
    t_init();
    t_lint();
    t_lock();
    t_irq(1'b1, 2'b10);
    t_irq(1'b0, 2'b01);
    t_reset(1'b1);
    end_sim();
  end
endmodule // csci_tb_top
